// ===== hw/cs_unit_pkg.sv
// Constants, register map and carrier types for the chip-select and wait-state unit.
package cs_unit_pkg;

  // Register I/O addresses.
  localparam logic [15:0] UPPER_OFS = 16'hFFA0;
  localparam logic [15:0] LOWER_OFS = 16'hFFA2;
  localparam logic [15:0] PERIPH_OFS = 16'hFFA4;
  localparam logic [15:0] MID_OFS = 16'hFFA6;
  localparam logic [15:0] MPMODE_OFS = 16'hFFA8;

  // Reset values; the upper region must work from reset so code can be fetched.
  localparam logic [15:0] UPPER_RST = 16'h80BF;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [15:0] PERIPH_RST = 16'h0000;
  localparam logic [15:0] MID_RST = 16'h0000;
  localparam logic [15:0] MPMODE_RST = 16'h0000;

  // Default configuration values written by start-up software.
  localparam logic [15:0] UPPER_DEF = 16'h80BF;
  localparam logic [15:0] LOWER_DEF = 16'h7FBF;
  localparam logic [15:0] MPMODE_DEF = 16'hA0BF;

  // Field positions.
  localparam int WAIT_MSB = 1;
  localparam int WAIT_LSB = 0;
  localparam int PWAIT_MSB = 2;
  localparam int READY_IGN_BIT = 2;
  localparam int REFRESH_BIT = 6;
  localparam int CS_MODE_BIT = 7;
  localparam int UPPER_BASE_MSB = 15;
  localparam int UPPER_BASE_LSB = 8;
  localparam int LOWER_TOP_MSB = 14;
  localparam int LOWER_TOP_LSB = 8;
  localparam int MID_BASE_MSB = 15;
  localparam int MID_BASE_LSB = 9;
  localparam int MID_SIZE_MSB = 14;
  localparam int MID_SIZE_LSB = 8;
  localparam int PER_BASE_MSB = 15;
  localparam int PER_BASE_LSB = 7;

  // Peripheral select layout in I/O space.
  localparam int NUM_PCS = 7;
  localparam logic [2:0] PCS_UNUSED = 3'h4;
  localparam logic [2:0] PCS_FIRST_HIGH = 3'h5;
  localparam logic [15:0] PCS_SPAN = 16'h0700;

  // Wait code to inserted wait states for the low peripheral selects.
  localparam logic [3:0] WAIT_MAP [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hF};

  // Enable timing.
  localparam int PERIOD_NS = 8;
  localparam int BASE_NS = 100;
  localparam int WAIT_NS = 25;

  typedef struct packed {
    logic io;
    logic wr;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic upper;
    logic lower;
    logic mid;
    logic [NUM_PCS-1:0] periph;
  } sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REG = 2'b01,
    ST_ACT = 2'b10
  } state_t;

endpackage

// ===== hw/enable_timer.sv
// Counts the length of one select enable from its wait-state setting.
`timescale 1ns/1ps
module enable_timer
  import cs_unit_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] wait_states,
  output logic time_up
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [8:0] en_ns;
  logic [6:0] load_cyc;

  always_comb begin
    en_ns = 9'(BASE_NS + WAIT_NS * int'(wait_states));
    load_cyc = 7'((int'(en_ns) + PERIOD_NS - 1) / PERIOD_NS - 1);
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = load_cyc;
    end else if (cnt_r != 7'h00) begin
      cnt_nxt = cnt_r - 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign time_up = (cnt_r == 7'h00);

endmodule

// ===== hw/chip_select_wait_state_unit.sv
// Region decoder, configuration registers and access sequencer of the chip-select unit.
// What this block does
// - The upper select covers memory from the programmed base up to the top, the top half megabyte by default.
// - The upper default value gives a 512K block from 0x80000 with three wait states.
// - The lower select covers memory from zero up to the programmed top, never above half a megabyte.
// - The lower default value gives three wait states, no refresh and no wait for external ready.
// - The mid select zero covers a programmed window, 256K at 0x80000 by default.
// - With the mode default, peripheral selects five and six are chip selects with three wait states.
// - Peripheral selects zero to three are chip selects, fifteen wait states with the default code.
// - Peripheral select zero starts at the programmed I/O base and each next one 0x100 higher.
// - The low peripheral wait code 0..7 inserts 0, 1, 2, 3, 5, 7, 9 or 15 wait states.
// - An enable lasts 100 ns plus 25 ns for each wait state.
`timescale 1ns/1ps
module chip_select_wait_state_unit
  import cs_unit_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire bus_req_t req,
  input wire logic ext_ready,
  output logic req_busy,
  output logic req_done,
  output logic [15:0] rdata,
  output sel_t sel,
  output logic refresh_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and ready synchroniser.

  logic rst_meta_r;
  logic rst_n_s;
  logic rdy_meta_r;
  logic rdy_sync_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdy_meta_r <= 1'b0;
      rdy_sync_r <= 1'b0;
    end else begin
      rdy_meta_r <= ext_ready;
      rdy_sync_r <= rdy_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and address decode.

  logic [15:0] upper_r, lower_r, per_r, mid_r, mpm_r;
  logic [15:0] upper_nxt, lower_nxt, per_nxt, mid_nxt, mpm_nxt;
  logic lower_en_r, per_en_r, mid_en_r, mpm_en_r;
  logic lower_en_nxt, per_en_nxt, mid_en_nxt, mpm_en_nxt;
  logic reg_hit;
  logic [15:0] reg_val;
  sel_t hit;
  logic [3:0] hit_ws;
  logic hit_ign;
  logic [15:0] per_base;
  logic [15:0] io_off;
  logic [2:0] pidx;
  logic [19:0] mid_base;
  logic [19:0] mid_size;
  logic take;

  always_comb begin
    reg_hit = 1'b1;
    reg_val = 16'h0000;
    if (!req.io) begin
      reg_hit = 1'b0;
    end else if (req.addr[15:0] == UPPER_OFS) begin
      reg_val = upper_r;
    end else if (req.addr[15:0] == LOWER_OFS) begin
      reg_val = lower_r;
    end else if (req.addr[15:0] == PERIPH_OFS) begin
      reg_val = per_r;
    end else if (req.addr[15:0] == MID_OFS) begin
      reg_val = mid_r;
    end else if (req.addr[15:0] == MPMODE_OFS) begin
      reg_val = mpm_r;
    end else begin
      reg_hit = 1'b0;
    end
  end

  always_comb begin
    hit = '0;
    hit_ws = 4'h0;
    hit_ign = 1'b1;
    per_base = {per_r[PER_BASE_MSB:PER_BASE_LSB], 7'h00};
    io_off = req.addr[15:0] - per_base;
    pidx = io_off[10:8];
    mid_base = {mid_r[MID_BASE_MSB:MID_BASE_LSB], 13'h0000};
    mid_size = {mpm_r[MID_SIZE_MSB:MID_SIZE_LSB], 13'h0000};
    if (req.io) begin
      // Peripheral ranges from the I/O base, 0x100 apart.
      if (!reg_hit && per_en_r && mpm_en_r && req.addr[15:0] >= per_base && io_off < PCS_SPAN &&
          pidx != PCS_UNUSED) begin
        if (pidx < PCS_UNUSED) begin
          // Low selects with mapped wait code.
          hit.periph = 7'(7'h01 << pidx);
          hit_ws = WAIT_MAP[per_r[PWAIT_MSB:WAIT_LSB]];
          hit_ign = per_r[READY_IGN_BIT];
        end else if (mpm_r[CS_MODE_BIT]) begin
          // High selects only in chip-select mode.
          hit.periph = 7'(7'h01 << pidx);
          hit_ws = {2'b00, mpm_r[WAIT_MSB:WAIT_LSB]};
          hit_ign = mpm_r[READY_IGN_BIT];
        end
      end
    // Mid window wins where it overlaps the upper region.
    end else if (mid_en_r && mpm_en_r && req.addr >= mid_base &&
                 {1'b0, req.addr} < ({1'b0, mid_base} + {1'b0, mid_size})) begin
      hit.mid = 1'b1;
      hit_ws = {2'b00, mid_r[WAIT_MSB:WAIT_LSB]};
      hit_ign = mid_r[READY_IGN_BIT];
    // Upper region up to the top of memory.
    end else if (req.addr[19:12] >= upper_r[UPPER_BASE_MSB:UPPER_BASE_LSB]) begin
      hit.upper = 1'b1;
      hit_ws = {2'b00, upper_r[WAIT_MSB:WAIT_LSB]};
      hit_ign = upper_r[READY_IGN_BIT];
    // Lower region from zero, bounded to the low half megabyte.
    end else if (lower_en_r && !req.addr[19] && req.addr[18:12] <= lower_r[LOWER_TOP_MSB:LOWER_TOP_LSB]) begin
      hit.lower = 1'b1;
      hit_ws = {2'b00, lower_r[WAIT_MSB:WAIT_LSB]};
      hit_ign = lower_r[READY_IGN_BIT];
    end
  end

  always_comb begin
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    per_nxt = per_r;
    mid_nxt = mid_r;
    mpm_nxt = mpm_r;
    lower_en_nxt = lower_en_r;
    per_en_nxt = per_en_r;
    mid_en_nxt = mid_en_r;
    mpm_en_nxt = mpm_en_r;
    if (take && reg_hit && req.wr) begin
      if (req.addr[15:0] == UPPER_OFS) begin
        // Upper value sets block and waits.
        upper_nxt = req.wdata;
      end else if (req.addr[15:0] == LOWER_OFS) begin
        lower_nxt = req.wdata;
        lower_en_nxt = 1'b1;
      end else if (req.addr[15:0] == PERIPH_OFS) begin
        per_nxt = req.wdata;
        per_en_nxt = 1'b1;
      end else if (req.addr[15:0] == MID_OFS) begin
        mid_nxt = req.wdata;
        mid_en_nxt = 1'b1;
      end else begin
        mpm_nxt = req.wdata;
        mpm_en_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      upper_r <= UPPER_RST;
      lower_r <= LOWER_RST;
      per_r <= PERIPH_RST;
      mid_r <= MID_RST;
      mpm_r <= MPMODE_RST;
      lower_en_r <= 1'b0;
      per_en_r <= 1'b0;
      mid_en_r <= 1'b0;
      mpm_en_r <= 1'b0;
    end else begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      per_r <= per_nxt;
      mid_r <= mid_nxt;
      mpm_r <= mpm_nxt;
      lower_en_r <= lower_en_nxt;
      per_en_r <= per_en_nxt;
      mid_en_r <= mid_en_nxt;
      mpm_en_r <= mpm_en_nxt;
    end
  end

  // Refresh stays off while the lower register holds a cleared refresh bit.
  assign refresh_en = lower_en_r && lower_r[REFRESH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  state_t state_r, state_nxt;
  sel_t sel_r, sel_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic ign_r, ign_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic io_r, io_nxt;
  logic start;
  logic time_up;

  // Register writes are taken only while the sequencer is idle.
  assign take = req_valid && (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    rdata_nxt = rdata_r;
    ws_nxt = ws_r;
    ign_nxt = ign_r;
    addr_nxt = addr_r;
    io_nxt = io_r;
    start = 1'b0;
    req_done = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          addr_nxt = req.addr;
          io_nxt = req.io;
          if (reg_hit) begin
            state_nxt = ST_REG;
            if (!req.wr) begin
              rdata_nxt = reg_val;
            end
          // No region hit ends the access with no select.
          end else if (hit != '0) begin
            sel_nxt = hit;
            ws_nxt = hit_ws;
            ign_nxt = hit_ign;
            start = 1'b1;
            state_nxt = ST_ACT;
          end else begin
            state_nxt = ST_REG;
          end
        end
      end
      ST_REG: begin
        req_done = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_ACT: begin
        // Hold the enable for its timed length and any external ready wait.
        if (time_up && (ign_r || rdy_sync_r)) begin
          req_done = 1'b1;
          sel_nxt = '0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        sel_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= ST_IDLE;
      sel_r <= '0;
      rdata_r <= 16'h0000;
      ws_r <= 4'h0;
      ign_r <= 1'b1;
      addr_r <= 20'h00000;
      io_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      rdata_r <= rdata_nxt;
      ws_r <= ws_nxt;
      ign_r <= ign_nxt;
      addr_r <= addr_nxt;
      io_r <= io_nxt;
    end
  end

  enable_timer u_timer (
    .clk(clk),
    .rst_n(rst_n_s),
    .start(start),
    .wait_states(hit_ws),
    .time_up(time_up)
  );

  assign req_busy = (state_r != ST_IDLE);
  assign rdata = rdata_r;
  assign sel = sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [6:0] act_cnt_r;
  logic [15:0] off_r;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      act_cnt_r <= 7'h00;
    end else if (start) begin
      act_cnt_r <= 7'h01;
    end else if (state_r == ST_ACT) begin
      act_cnt_r <= act_cnt_r + 7'h01;
    end
  end

  assign off_r = addr_r[15:0] - per_base;

  a_upper_region: assert property (@(posedge clk) disable iff (!rst_n_s)
    sel_r.upper |-> !io_r && addr_r[19:12] >= upper_r[UPPER_BASE_MSB:UPPER_BASE_LSB])
    else $error("upper select outside its region");

  a_upper_default: assert property (@(posedge clk) disable iff (!rst_n_s)
    start && hit.upper && upper_r == UPPER_DEF |-> req.addr >= 20'h80000 ##1 ws_r == 4'h3 && sel_r.upper)
    else $error("upper default not 512K with three waits");

  a_lower_region: assert property (@(posedge clk) disable iff (!rst_n_s)
    sel_r.lower |-> !addr_r[19] && addr_r[18:12] <= lower_r[LOWER_TOP_MSB:LOWER_TOP_LSB])
    else $error("lower select outside its region");

  a_lower_default: assert property (@(posedge clk) disable iff (!rst_n_s)
    sel_r.lower && lower_r == LOWER_DEF |-> ws_r == 4'h3 && ign_r && !refresh_en)
    else $error("lower default settings wrong");

  a_mid_window: assert property (@(posedge clk) disable iff (!rst_n_s)
    sel_r.mid |-> addr_r >= mid_base && {1'b0, addr_r} < ({1'b0, mid_base} + {1'b0, mid_size}))
    else $error("mid select outside its window");

  a_high_pcs_wait: assert property (@(posedge clk) disable iff (!rst_n_s)
    (sel_r.periph[5] || sel_r.periph[6]) && mpm_r == MPMODE_DEF |-> ws_r == 4'h3 && mpm_r[CS_MODE_BIT])
    else $error("high peripheral select wait wrong");

  a_low_pcs_wait: assert property (@(posedge clk) disable iff (!rst_n_s)
    $rose(|sel_r.periph[3:0]) |-> ws_r == WAIT_MAP[per_r[PWAIT_MSB:WAIT_LSB]])
    else $error("low peripheral wait not mapped");

  a_low_pcs_slow: assert property (@(posedge clk) disable iff (!rst_n_s)
    |sel_r.periph[3:0] && per_r[PWAIT_MSB:WAIT_LSB] == 3'h7 |-> ws_r == 4'hF)
    else $error("low peripheral default not fifteen waits");

  a_pcs_address: assert property (@(posedge clk) disable iff (!rst_n_s)
    sel_r.periph != '0 |-> io_r && off_r < PCS_SPAN && sel_r.periph == 7'(7'h01 << off_r[10:8]))
    else $error("peripheral select on wrong range");

  a_enable_length: assert property (@(posedge clk) disable iff (!rst_n_s)
    state_r == ST_ACT && req_done && ign_r |->
      int'(act_cnt_r) == (BASE_NS + WAIT_NS * int'(ws_r) + PERIOD_NS - 1) / PERIOD_NS)
    else $error("enable length wrong");

  a_one_select: assert property (@(posedge clk) disable iff (!rst_n_s)
    $onehot0(sel_r) && (state_r == ST_ACT || sel_r == '0))
    else $error("more than one select or stray select");

endmodule

// ===== tb/local_bus_chips.sv
// Behavioural model of the memory and peripheral chips that answer on the select lines.
`timescale 1ns/1ps
module local_bus_chips
  import cs_unit_pkg::*;
#(
  parameter int SLOW_CYCLES = 40
) (
  input wire logic clk,
  input wire sel_t sel,
  input wire logic slow,
  output logic ext_ready
);
  int held = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Counts how long the current select has been active; a new access starts from zero.
  always @(posedge clk) begin
    if (sel == '0) begin
      held <= 0;
    end else begin
      held <= held + 1;
    end
  end

  // A chip that is not selected never leaves ready asserted between accesses.
  assign ext_ready = (sel != '0) && (!slow || held >= SLOW_CYCLES);
endmodule

// ===== tb/chip_select_wait_state_unit_tb.sv
// Self-checking testbench for the chip-select and wait-state unit.
`timescale 1ns/1ps
module chip_select_wait_state_unit_tb
  import cs_unit_pkg::*;
;
  logic clk, rstn, req_valid, ext_ready, slow, req_busy, req_done, refresh_en;
  bus_req_t req;
  logic [15:0] rdata, rd;
  logic busy1;
  sel_t sel, seen_sel;
  int cnt, multi, miscompares, tests_run;
  int ws_tab [0:7] = '{0, 1, 2, 3, 5, 7, 9, 15};
  localparam logic [9:0] sel_up = 10'h200;
  localparam logic [9:0] sel_lo = 10'h100;
  localparam logic [9:0] sel_mid = 10'h080;

  chip_select_wait_state_unit DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .ext_ready(ext_ready), .req_busy(req_busy), .req_done(req_done), .rdata(rdata), .sel(sel),
    .refresh_en(refresh_en));
  local_bus_chips chips (.clk(clk), .sel(sel), .slow(slow), .ext_ready(ext_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic int ncyc(input int ws);
    return (100 + 25 * ws + 7) / 8;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus access, entered at a falling edge; counts select cycles until done.
  task automatic access(input logic io, input logic wr, input logic [19:0] addr, input logic [15:0] wd);
    req_valid = 1'b1;
    req = '{io: io, wr: wr, addr: addr, wdata: wd};
    cnt = 0;
    multi = 0;
    seen_sel = '0;
    @(negedge clk);
    req_valid = 1'b0;
    busy1 = req_busy;
    for (int i = 0; i < 300; i++) begin
      if (sel !== '0) begin
        cnt++;
        seen_sel = seen_sel | sel;
      end
      if ($countones(sel) > 1) begin
        multi = 1;
      end
      if (req_done === 1'b1) begin
        break;
      end
      @(negedge clk);
    end
    rd = rdata;
    @(negedge clk);
  endtask

  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    access(1'b1, 1'b1, {4'h0, a}, d);
  endtask

  task automatic rreg(input logic [15:0] a, input logic [15:0] e);
    access(1'b1, 1'b0, {4'h0, a}, 16'h0000);
    check("register", rd, e);
  endtask

  task automatic region(input logic io, input logic [19:0] addr, input logic [9:0] es, input int ec);
    access(io, 1'b0, addr, 16'h0000);
    check("select", seen_sel, es);
    check("cycles", cnt, ec);
    check("one_hot", multi, 0);
    check("busy", busy1, 1'b1);
    check("idle", {req_busy, sel}, 11'h000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 20000);
    miscompares++;
    test_done();
  end

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check("sel_idle", sel, 10'h000);
    rreg(UPPER_OFS, 16'h80BF);
    rreg(LOWER_OFS, 16'h0000);
    rreg(MPMODE_OFS, 16'h0000);
    region(1'b0, 20'h90000, sel_up, ncyc(3));
    region(1'b0, 20'hFFFFE, sel_up, ncyc(3));
    region(1'b0, 20'h7FFFE, 10'h000, 0);
    region(1'b1, 20'h0FFAA, 10'h000, 0);
    wreg(UPPER_OFS, 16'h80BF);
    wreg(LOWER_OFS, 16'h7FBF);
    wreg(MPMODE_OFS, 16'hA0BF);
    wreg(MID_OFS, 16'h81FF);
    wreg(PERIPH_OFS, 16'h007F);
    rreg(LOWER_OFS, 16'h7FBF);
    rreg(PERIPH_OFS, 16'h007F);
    rreg(MID_OFS, 16'h81FF);
    region(1'b0, 20'hC0000, sel_up, ncyc(3));
    region(1'b0, 20'h80000, sel_mid, ncyc(3));
    region(1'b0, 20'hBFFFE, sel_mid, ncyc(3));
    region(1'b0, 20'h00000, sel_lo, ncyc(3));
    region(1'b0, 20'h7FFFE, sel_lo, ncyc(3));
    check("refresh", refresh_en, 1'b0);
    // peripheral select spacing in I/O space.
    for (int n = 0; n < 7; n++) begin
      region(1'b1, 20'(n * 256 + 16), (n == 4) ? 10'h000 : 10'(1 << n),
        (n < 4) ? ncyc(15) : ((n == 4) ? 0 : ncyc(3)));
    end
    region(1'b1, 20'h00700, 10'h000, 0);
    // wait code map and enable length.
    for (int c = 0; c < 8; c++) begin
      wreg(PERIPH_OFS, 16'(c));
      region(1'b1, 20'h00300, 10'h008, ncyc(ws_tab[c]));
    end
    wreg(LOWER_OFS, 16'h7FFF);
    check("refresh", refresh_en, 1'b1);
    wreg(LOWER_OFS, 16'h7FBB);
    check("refresh", refresh_en, 1'b0);
    slow = 1'b1;
    access(1'b0, 1'b0, 20'h01000, 16'h0000);
    check("ready_wait", cnt > ncyc(3), 1);
    wreg(LOWER_OFS, 16'h7FBF);
    region(1'b0, 20'h01000, sel_lo, ncyc(3));
    slow = 1'b0;
    test_done();
  end
endmodule
